// File: rtl/ogr_host_port.sv
/*
 Host port and display memory of a 128x64 monochrome graphic display:
 parallel, serial and i2c byte capture, command decode, bit-mapped
 memory, start line and remap, display on/off with turn-on delay.
 Assumes pins arrive asynchronously and a panel scanner on i_clock
 asks for one pixel per cycle at i_scan_row / i_scan_col.
*/
// Function
// [R1] memory of 128 columns by 64 rows in eight pages of eight rows
// [R2] one data byte fills the eight row bits at the column pointer
// [R3] bit 0 lands in the top row of the page, bit 7 bottom
// [R4] remap reverses row order and column order by command
// [R5] start line register set by its command scrolls the image
// [R6] held reset returns registers to defaults within the pulse
// [R7] display-on command enables drivers after 100 ms
// [R8] display-off command blanks outputs at once
// [R9] memory contents survive display off
// [R10] data/command line marks each byte's kind
// [R11] line low means command, high means display data
// [R12] three strap inputs pick parallel, serial or i2c
// [R13] chip select low frames access; activity ignored otherwise
// [R14] parallel read/write input sets direction on the data bus
// [R15] serial: bit 0 clock, bit 1 data in
// [R16] i2c: bit 2 data out, bit 1 data in, bit 0 clock
// [R17] host should program contrast, 1/64 duty and 105 Hz
`include "ogr_params.svh"
`timescale 1ns/1ps
`default_nettype none

module ogr_host_port #(
    parameter int ON_DELAY_CYCLES = `OGR_ON_DELAY_CYC
) (
    input  wire logic       i_clock,
    input  wire logic       i_rst_b,
    input  wire logic       i_hw_reset_n,
    input  wire logic       i_bus_select_bit0,
    input  wire logic       i_bus_select_bit1,
    input  wire logic       i_bus_select_bit2,
    input  wire logic       i_cs_n,
    input  wire logic       i_dc,
    input  wire logic       i_read,
    input  wire logic       i_enable,
    input  wire logic [7:0] i_data,
    output logic      [7:0] o_data,
    output logic      [7:0] o_data_oe_n,
    input  wire logic [5:0] i_scan_row,
    input  wire logic [6:0] i_scan_col,
    output logic            o_pixel,
    output logic            o_panel_on
);
    ////////////////////////////////////////////////////////////////////
    logic [15:0] s_all;
    logic        s_hw_n, s_cs_n, s_dc, s_rd, s_en;
    logic [2:0]  s_bs;
    logic [7:0]  s_d;
    logic        core_rst;
    logic        d0_p, d1_p, en_p;
    ogr_pkg::ogr_mode_t mode;

    // all pins pass two flops before use
    ogr_sync #(.WIDTH(16), .INIT(16'h4000)) u_sync (
        .i_clock (i_clock),
        .i_rst_b (i_rst_b),
        .i_async ({i_hw_reset_n, i_cs_n, i_dc, i_read, i_enable,
                   i_bus_select_bit2, i_bus_select_bit1, i_bus_select_bit0, i_data}),
        .o_sync  (s_all)
    );
    assign {s_hw_n, s_cs_n, s_dc, s_rd, s_en, s_bs, s_d} = s_all;

    // stretch reset until synced straps are valid, else the mode latches the init value
    logic [1:0] boot_cnt;
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            boot_cnt <= 2'h0;
        end else if (boot_cnt != 2'h3) begin
            boot_cnt <= boot_cnt + 2'h1;
        end
    end
    assign core_rst = !i_rst_b || !s_hw_n || boot_cnt != 2'h3; // see [R6]

    // straps sampled throughout reset, frozen after release
    always_ff @(posedge i_clock) begin
        if (core_rst) begin
            case (s_bs) // see [R12]
                `OGR_BS_PARALLEL: mode <= ogr_pkg::OGR_MODE_PAR;
                `OGR_BS_I2C:      mode <= ogr_pkg::OGR_MODE_I2C;
                default:          mode <= ogr_pkg::OGR_MODE_SPI;
            endcase
        end
    end

    // previous samples for edge detection
    always_ff @(posedge i_clock) begin
        if (core_rst) begin
            d0_p <= 1'b0;
            d1_p <= 1'b0;
            en_p <= 1'b0;
        end else begin
            d0_p <= s_d[0];
            d1_p <= s_d[1];
            en_p <= s_en;
        end
    end

    logic clk_rise, clk_fall, en_fall;
    assign clk_rise = s_d[0] && !d0_p;
    assign clk_fall = !s_d[0] && d0_p;
    assign en_fall  = !s_en && en_p;

    ////////////////////////////////////////////////////////////////////
    logic       cap_stb, cap_dc, par_rd_stb;
    logic [7:0] cap_byte, spi_sh;
    logic [2:0] spi_cnt;

    // parallel and serial byte capture, gated by chip select
    always_ff @(posedge i_clock) begin
        if (core_rst) begin
            cap_stb    <= 1'b0;
            cap_dc     <= 1'b0;
            cap_byte   <= 8'h00;
            par_rd_stb <= 1'b0;
            spi_cnt    <= 3'h0;
            spi_sh     <= 8'h00;
        end else begin
            cap_stb    <= 1'b0;
            par_rd_stb <= 1'b0;
            if (s_cs_n) begin // see [R13]
                spi_cnt <= 3'h0;
            end else if (mode == ogr_pkg::OGR_MODE_PAR && en_fall) begin
                // direction from the read/write input; see [R14]
                cap_stb    <= !s_rd;
                par_rd_stb <= s_rd;
                cap_byte   <= s_d;
                cap_dc     <= s_dc; // see [R10]
            end else if (mode == ogr_pkg::OGR_MODE_SPI && clk_rise) begin
                spi_sh  <= {spi_sh[6:0], s_d[1]}; // see [R15]
                spi_cnt <= spi_cnt + 3'h1;
                if (spi_cnt == 3'h7) begin
                    cap_stb  <= 1'b1;
                    cap_byte <= {spi_sh[6:0], s_d[1]};
                    cap_dc   <= s_dc;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    ogr_pkg::ogr_i2c_state_t i2c_st;
    logic [3:0] i2c_cnt;
    logic [7:0] i2c_sh, i2c_byte;
    logic       i2c_ack, i2c_co, i2c_dc, i2c_stb;
    logic       i2c_start, i2c_stop;
    assign i2c_start = s_d[0] && d0_p && !s_d[1] && d1_p;
    assign i2c_stop  = s_d[0] && d0_p && s_d[1] && !d1_p;

    // i2c slave: address, control byte carrying data/command, data
    always_ff @(posedge i_clock) begin
        if (core_rst || mode != ogr_pkg::OGR_MODE_I2C || s_cs_n) begin
            i2c_st   <= ogr_pkg::OGR_I2C_IDLE;
            i2c_cnt  <= 4'h0;
            i2c_sh   <= 8'h00;
            i2c_byte <= 8'h00;
            i2c_ack  <= 1'b0;
            i2c_co   <= 1'b0;
            i2c_dc   <= 1'b0;
            i2c_stb  <= 1'b0;
        end else begin
            i2c_stb <= 1'b0;
            if (i2c_start) begin
                i2c_st  <= ogr_pkg::OGR_I2C_ADDR;
                i2c_cnt <= 4'h0;
                i2c_ack <= 1'b0;
            end else if (i2c_stop) begin
                i2c_st  <= ogr_pkg::OGR_I2C_IDLE;
                i2c_ack <= 1'b0;
            end else if (clk_rise && !i2c_ack && i2c_st != ogr_pkg::OGR_I2C_IDLE) begin
                i2c_sh  <= {i2c_sh[6:0], s_d[1]}; // see [R16]
                i2c_cnt <= i2c_cnt + 4'h1;
            end else if (clk_fall && i2c_ack) begin
                i2c_ack <= 1'b0;
                i2c_cnt <= 4'h0;
            end else if (clk_fall && i2c_cnt == 4'h8) begin
                case (i2c_st)
                    ogr_pkg::OGR_I2C_ADDR: begin
                        // write-only slave: reads are not acknowledged
                        if (i2c_sh[7:1] == `OGR_I2C_ADDR && !i2c_sh[0]) begin
                            i2c_ack <= 1'b1;
                            i2c_st  <= ogr_pkg::OGR_I2C_CTRL;
                        end else begin
                            i2c_st <= ogr_pkg::OGR_I2C_IDLE;
                        end
                    end
                    ogr_pkg::OGR_I2C_CTRL: begin
                        i2c_ack <= 1'b1;
                        i2c_co  <= i2c_sh[7];
                        i2c_dc  <= i2c_sh[6]; // see [R10]
                        i2c_st  <= ogr_pkg::OGR_I2C_DATA;
                    end
                    ogr_pkg::OGR_I2C_DATA: begin
                        i2c_ack  <= 1'b1;
                        i2c_stb  <= 1'b1;
                        i2c_byte <= i2c_sh;
                        i2c_st   <= i2c_co ? ogr_pkg::OGR_I2C_CTRL : ogr_pkg::OGR_I2C_DATA;
                    end
                    default: i2c_st <= ogr_pkg::OGR_I2C_IDLE;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    logic       byte_stb, byte_dc, data_stb, cmd_stb, cmd_on, cmd_off;
    logic [7:0] byte_val;
    logic       expect_start, row_remap, col_remap, disp_on;
    logic [5:0] start_line;
    logic [2:0] page;
    logic [6:0] col;
    logic [9:0] idx;
    logic [7:0] mem [0:`OGR_PAGES*`OGR_COLS-1]; // see [R1]

    // one byte stream whatever the bus
    assign byte_stb = cap_stb || i2c_stb;
    assign byte_val = i2c_stb ? i2c_byte : cap_byte;
    assign byte_dc  = i2c_stb ? i2c_dc : cap_dc;
    assign data_stb = byte_stb && byte_dc;  // see [R11]
    assign cmd_stb  = byte_stb && !byte_dc; // see [R11]
    assign cmd_on   = cmd_stb && !expect_start && byte_val == `OGR_CMD_DISP_ON;
    assign cmd_off  = cmd_stb && !expect_start && byte_val == `OGR_CMD_DISP_OFF;
    assign idx      = {page, col};

    // command decode and column pointer
    always_ff @(posedge i_clock) begin
        if (core_rst) begin
            expect_start <= 1'b0;
            start_line   <= 6'h00;
            row_remap    <= 1'b0;
            col_remap    <= 1'b0;
            page         <= 3'h0;
            col          <= 7'h00;
        end else if (cmd_stb) begin
            if (expect_start) begin
                start_line   <= byte_val[5:0]; // see [R5]
                expect_start <= 1'b0;
            end else begin
                case (byte_val)
                    `OGR_CMD_START_LINE: expect_start <= 1'b1;
                    `OGR_CMD_COL_NORMAL: col_remap <= 1'b0;
                    `OGR_CMD_COL_REMAP:  col_remap <= 1'b1; // see [R4]
                    `OGR_CMD_ROW_NORMAL: row_remap <= 1'b0;
                    `OGR_CMD_ROW_REMAP:  row_remap <= 1'b1; // see [R4]
                    default: begin
                        if (byte_val[7:4] == `OGR_CMD_PAGE_HI && !byte_val[3]) begin
                            page <= byte_val[2:0];
                        end else if (byte_val[7:4] == `OGR_CMD_COLLO_HI) begin
                            col[3:0] <= byte_val[3:0];
                        end else if (byte_val[7:4] == `OGR_CMD_COLHI_HI) begin
                            col[6:4] <= byte_val[2:0];
                        end
                    end
                endcase
            end
        end else if (data_stb || par_rd_stb) begin
            col <= col + 7'h01; // wraps within the page; see [R2]
        end
    end

    // memory has no reset so the image outlives display off; see [R9]
    always_ff @(posedge i_clock) begin
        if (data_stb) begin
            mem[idx] <= byte_val; // see [R2]
        end
    end

    ////////////////////////////////////////////////////////////////////
    logic [21:0] on_cnt;

    // display on/off and turn-on delay
    always_ff @(posedge i_clock) begin
        if (core_rst || cmd_off) begin
            disp_on    <= 1'b0;
            o_panel_on <= 1'b0; // see [R8]
            on_cnt     <= 22'h000000;
        end else if (cmd_on) begin
            disp_on <= 1'b1;
            if (!o_panel_on) begin
                on_cnt <= 22'h000000;
            end
        end else if (disp_on && !o_panel_on) begin
            if (on_cnt == 22'(ON_DELAY_CYCLES - 1)) begin
                o_panel_on <= 1'b1; // see [R7]
            end else begin
                on_cnt <= on_cnt + 22'h000001;
            end
        end
    end

    // bus drive: parallel read data, i2c acknowledge pull-down
    always_ff @(posedge i_clock) begin
        if (core_rst) begin
            o_data      <= 8'h00;
            o_data_oe_n <= 8'hFF;
        end else if (mode == ogr_pkg::OGR_MODE_I2C) begin
            o_data      <= 8'h00;
            o_data_oe_n <= {5'h1F, !i2c_ack, 2'h3}; // see [R16]
        end else begin
            o_data      <= mem[idx];
            o_data_oe_n <= {8{!(mode == ogr_pkg::OGR_MODE_PAR && !s_cs_n && s_en && s_rd)}}; // see [R14]
        end
    end

    ////////////////////////////////////////////////////////////////////
    logic [5:0] mem_row;
    logic [6:0] mem_col;

    // scan address to memory address: remap then start line
    always_comb begin
        mem_row = 6'((row_remap ? ~i_scan_row : i_scan_row) + start_line); // see [R4]
        mem_col = col_remap ? ~i_scan_col : i_scan_col;
    end

    // bit 0 of a byte is the top row of its page
    always_ff @(posedge i_clock) begin
        if (core_rst) begin
            o_pixel <= 1'b0;
        end else begin
            o_pixel <= o_panel_on && mem[{mem_row[5:3], mem_col}][mem_row[2:0]]; // see [R3]
        end
    end

    ////////////////////////////////////////////////////////////////////
    logic [6:0] hw_low_cnt;

    // how long the reset pin has been seen low
    always_ff @(posedge i_clock) begin
        if (!i_rst_b || s_hw_n) begin
            hw_low_cnt <= 7'h00;
        end else if (hw_low_cnt != 7'h7F) begin
            hw_low_cnt <= hw_low_cnt + 7'h01;
        end
    end

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_b);

    panel_on_delay_a: assert property ($rose(o_panel_on) |-> $past(disp_on) && $past(on_cnt) == 22'(ON_DELAY_CYCLES - 1)) // see [R7]
        else $error("panel enabled without full turn-on delay");
    display_off_a: assert property (cmd_off |=> !o_panel_on && !disp_on ##1 !o_pixel) // see [R8]
        else $error("display-off did not blank");
    mem_write_a: assert property (data_stb |=> mem[$past(idx)] == $past(byte_val)) // see [R2]
        else $error("data byte not stored at pointer");
    col_advance_a: assert property (data_stb |=> col == 7'($past(col) + 7'h01)) // see [R2]
        else $error("column pointer did not advance");
    reset_default_a: assert property (hw_low_cnt >= 7'(`OGR_RESET_CYC) |-> !disp_on && !o_panel_on && start_line == 6'h00 && !row_remap && !col_remap) // see [R6]
        else $error("registers not at default within reset pulse");
    cs_ignore_a: assert property (s_cs_n && mode != ogr_pkg::OGR_MODE_I2C |=> !cap_stb && !par_rd_stb) // see [R13]
        else $error("bus activity taken while deselected");
    start_line_a: assert property (cmd_stb && expect_start |=> start_line == $past(byte_val[5:0]) && !expect_start) // see [R5]
        else $error("start line not loaded");
    i2c_ack_a: assert property ($rose(i2c_ack) |=> !o_data_oe_n[2] && !o_data[2] && &o_data_oe_n[1:0]) // see [R16]
        else $error("acknowledge not driven on data out");
    bus_mode_a: assert property (mode != ogr_pkg::OGR_MODE_PAR |=> &o_data_oe_n[7:3]) // see [R12]
        else $error("upper data lines driven outside parallel mode");
endmodule

`default_nettype wire

// File: rtl/ogr_params.svh
/*
 Constants of the graphic display host port: geometry, commands,
 bus-select codes and timing. Assumes inclusion by bare name.
*/
`ifndef OGR_PARAMS_SVH
`define OGR_PARAMS_SVH

// geometry: eight pages of 128 one-byte columns
`define OGR_COLS            128
`define OGR_ROWS            64
`define OGR_PAGES           8

// command bytes
`define OGR_CMD_DISP_OFF    8'hAE
`define OGR_CMD_DISP_ON     8'hAF
`define OGR_CMD_START_LINE  8'hD3
`define OGR_CMD_COL_NORMAL  8'hA0
`define OGR_CMD_COL_REMAP   8'hA1
`define OGR_CMD_ROW_NORMAL  8'hC0
`define OGR_CMD_ROW_REMAP   8'hC8
`define OGR_CMD_PAGE_HI     4'hB
`define OGR_CMD_COLLO_HI    4'h0
`define OGR_CMD_COLHI_HI    4'h1

// strap codes {bit2,bit1,bit0}
`define OGR_BS_PARALLEL     3'h4
`define OGR_BS_SERIAL       3'h0
`define OGR_BS_I2C          3'h2

// i2c slave address, value arbitrary
`define OGR_I2C_ADDR        7'h3C

// timing
`define OGR_CLK_KHZ         25000
`define OGR_CLK_NS          40
`define OGR_RESET_MIN_NS    3000
`define OGR_RESET_CYC       ((`OGR_RESET_MIN_NS + `OGR_CLK_NS - 1) / `OGR_CLK_NS)
`define OGR_ON_DELAY_MS     100
`define OGR_ON_DELAY_CYC    (`OGR_ON_DELAY_MS * `OGR_CLK_KHZ)

`endif

// File: rtl/ogr_pkg.sv
/*
 Types of the graphic display host port.
 Assumes nothing of its surroundings.
*/
package ogr_pkg;
    typedef enum logic [2:0] {
        OGR_MODE_PAR = 3'b001,
        OGR_MODE_SPI = 3'b010,
        OGR_MODE_I2C = 3'b100
    } ogr_mode_t;

    typedef enum logic [3:0] {
        OGR_I2C_IDLE = 4'b0001,
        OGR_I2C_ADDR = 4'b0010,
        OGR_I2C_CTRL = 4'b0100,
        OGR_I2C_DATA = 4'b1000
    } ogr_i2c_state_t;
endpackage

// File: rtl/ogr_sync.sv
/*
 Two-flop synchroniser for a group of pin inputs.
 Assumes the pins are quasi-static relative to the clock.
*/
`timescale 1ns/1ps
`default_nettype none

module ogr_sync #(
    parameter int              WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input  wire logic             i_clock,
    input  wire logic             i_rst_b,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] stage1;

    // first stage is read only by the second
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            stage1 <= INIT;
            o_sync <= INIT;
        end else begin
            stage1 <= i_async;
            o_sync <= stage1;
        end
    end
endmodule

`default_nettype wire

// File: verification/ogr_host_model.sv
/*
 Behavioural host microcontroller for the graphic display host port:
 parallel strobed transfers and four-wire serial bytes, called as tasks.
 Assumes the bench resolves the shared data bus from the device enables.
*/
`timescale 1ns/1ps
`default_nettype none

module ogr_host_model (
    input  wire logic       i_clock,
    input  wire logic [7:0] i_bus,
    output logic            o_cs_n,
    output logic            o_dc,
    output logic            o_read,
    output logic            o_enable,
    output logic      [7:0] o_data
);
    // strobe phases held above the device's 3-clock sampling floor
    localparam int HOLD = 5;

    ////////////////////////////////////////////////////////////////////////
    // idle pins: deselected, serial clock parked low
    initial begin
        o_cs_n   = 1'b1;
        o_dc     = 1'b0;
        o_read   = 1'b0;
        o_enable = 1'b0;
        o_data   = 8'h00;
    end

    // n clocks, then just past the edge
    task automatic step(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // parallel transfer; sel low strobes with chip select left inactive
    task automatic par_xfer(input logic sel, input logic dc, input logic rd,
                            input logic [7:0] val, output logic [7:0] got);
        step(1);
        o_cs_n   = !sel;
        o_dc     = dc;
        o_read   = rd;
        o_data   = rd ? ~o_data : val;   // released bus never keeps last value
        o_enable = 1'b1;
        repeat (HOLD) @(posedge i_clock);
        got      = i_bus;
        #1;
        o_enable = 1'b0;
        step(HOLD);
        o_cs_n   = 1'b1;
        o_read   = 1'b0;
        o_data   = ~o_data;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // serial byte, msb first on bit 1, clock on bit 0
    task automatic ser_xfer(input logic dc, input logic [7:0] val);
        step(1);
        o_cs_n = 1'b0;
        o_dc   = dc;
        for (int i = 7; i >= 0; i--) begin
            o_data[1] = val[i];
            step(HOLD);
            o_data[0] = 1'b1;
            step(HOLD);
            o_data[0] = 1'b0;
        end
        step(HOLD);
        o_cs_n    = 1'b1;
        o_data[1] = ~o_data[1];
    endtask

    ////////////////////////////////////////////////////////////////////////
    // i2c: start, address, control, one byte, stop; acks seen on bit 2
    task automatic i2c_xfer(input logic [7:0] adr, input logic [7:0] ctl,
                            input logic [7:0] val, output logic [2:0] acks);
        logic [23:0] s;
        s           = {adr, ctl, val};
        o_cs_n      = 1'b0;
        o_data[2:0] = 3'b111;            // released line reads high
        step(HOLD);
        o_data[1]   = 1'b0;              // start
        step(HOLD);
        for (int k = 2; k >= 0; k--) begin
            for (int i = 0; i < 9; i++) begin
                o_data[0] = 1'b0;
                step(HOLD);
                o_data[1] = (i < 8) ? s[23] : 1'b1;
                if (i < 8) begin
                    s = {s[22:0], 1'b0};
                end
                step(HOLD);
                o_data[0] = 1'b1;
                step(HOLD);
                if (i == 8) begin
                    acks[k] = !i_bus[2];
                end
            end
        end
        o_data[0] = 1'b0;
        step(HOLD);
        o_data[1] = 1'b0;
        step(HOLD);
        o_data[0] = 1'b1;
        step(HOLD);
        o_data[1] = 1'b1;                // stop
        step(HOLD);
        o_cs_n      = 1'b1;
        o_data[2:0] = 3'b000;
    endtask
endmodule

`default_nettype wire

// File: verification/tb_top.sv
/*
 Self-checking bench for the graphic display host port: layout, remap,
 start line, chip select, read back, display on/off, pin reset, serial.
 Assumes a 25 MHz clock and a short turn-on delay parameter.
*/
`include "ogr_params.svh"
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    localparam int ON_CYC = 20;

    logic       clock = 1'b0;
    logic       rst_b = 1'b0;
    logic       hw_reset_n = 1'b1;
    logic [2:0] bus_sel = `OGR_BS_PARALLEL;
    logic [5:0] scan_row = 6'h00;
    logic [6:0] scan_col = 7'h00;
    logic       cs_n;
    logic       dc;
    logic       rd;
    logic       en;
    logic [7:0] host_data;
    logic [7:0] dev_data;
    logic [7:0] dev_oe_n;
    logic [7:0] bus;
    logic       pixel;
    logic       panel_on;
    logic [7:0] junk;
    logic [7:0] got;
    int         n_errors = 0;
    int         checks = 0;

    always #20 clock = ~clock;

    // device drives a bit only where its enable is low
    assign bus = (dev_data & ~dev_oe_n) | (host_data & dev_oe_n);

    ogr_host_port #(.ON_DELAY_CYCLES(ON_CYC)) ogr_host_port_inst (
        .i_clock(clock), .i_rst_b(rst_b), .i_hw_reset_n(hw_reset_n),
        .i_bus_select_bit0(bus_sel[0]), .i_bus_select_bit1(bus_sel[1]),
        .i_bus_select_bit2(bus_sel[2]), .i_cs_n(cs_n), .i_dc(dc), .i_read(rd),
        .i_enable(en), .i_data(bus), .o_data(dev_data), .o_data_oe_n(dev_oe_n),
        .i_scan_row(scan_row), .i_scan_col(scan_col), .o_pixel(pixel),
        .o_panel_on(panel_on)
    );

    ogr_host_model ogr_host_model_inst (
        .i_clock(clock), .i_bus(bus), .o_cs_n(cs_n), .o_dc(dc),
        .o_read(rd), .o_enable(en), .o_data(host_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // comparisons and verdict
    task automatic check_bit(input logic g, input logic e);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%0h exp=%0h", $time, g, e);
        end
    endtask

    task automatic check_byte(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%0h exp=%0h", $time, g, e);
        end
    endtask

    task automatic print_verdict();
        $display("errors=%0d checks=%0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // helpers: command, data, pixel probe, bounded turn-on wait
    task automatic cmd(input logic [7:0] v);
        ogr_host_model_inst.par_xfer(1'b1, 1'b0, 1'b0, v, junk);
    endtask

    task automatic dat(input logic [7:0] v);
        ogr_host_model_inst.par_xfer(1'b1, 1'b1, 1'b0, v, junk);
    endtask

    // pixel is registered, so look two edges after the address moves
    task automatic pix(input logic [5:0] r, input logic [6:0] c, input logic e);
        @(posedge clock);
        #1;
        scan_row = r;
        scan_col = c;
        repeat (2) @(posedge clock);
        #1;
        check_bit(pixel, e);
    endtask

    task automatic wait_on();
        int n;
        n = 0;
        check_bit(panel_on, 1'b0);
        while (panel_on !== 1'b1 && n < 200) begin
            @(posedge clock);
            #1;
            n++;
        end
        if (n >= 200) begin
            n_errors++;
            print_verdict();
        end
        check_bit(n >= 10 && n <= ON_CYC + 10, 1'b1);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_layout();
        cmd(`OGR_CMD_DISP_ON);
        wait_on();
        cmd(8'hB0);
        cmd(8'h00);
        cmd(8'h10);
        dat(8'h81);
        dat(8'h02);
        pix(6'd0, 7'd0, 1'b1);
        pix(6'd7, 7'd0, 1'b1);
        pix(6'd1, 7'd0, 1'b0);
        pix(6'd1, 7'd1, 1'b1);
    endtask

    task automatic t_remap();
        cmd(8'hA1);
        pix(6'd0, 7'd127, 1'b1);
        pix(6'd1, 7'd127, 1'b0);
        cmd(8'hA0);
        cmd(8'hC8);
        pix(6'd63, 7'd0, 1'b1);
        pix(6'd62, 7'd1, 1'b1);
        pix(6'd62, 7'd0, 1'b0);
        cmd(8'hC0);
    endtask

    task automatic t_start_line();
        cmd(`OGR_CMD_START_LINE);
        cmd(8'h01);
        pix(6'd0, 7'd1, 1'b1);
        pix(6'd0, 7'd0, 1'b0);
        pix(6'd6, 7'd0, 1'b1);
        cmd(`OGR_CMD_START_LINE);
        cmd(8'h00);
    endtask

    // strobe with chip select high must leave memory and pointer alone
    task automatic t_cs_read();
        cmd(8'h00);
        cmd(8'h10);
        ogr_host_model_inst.par_xfer(1'b0, 1'b1, 1'b0, 8'h00, junk);
        ogr_host_model_inst.par_xfer(1'b1, 1'b1, 1'b1, 8'h00, got);
        check_byte(got, 8'h81);
        ogr_host_model_inst.par_xfer(1'b1, 1'b1, 1'b1, 8'h00, got);
        check_byte(got, 8'h02);
        check_byte(dev_oe_n, 8'hFF);
    endtask

    // a data byte equal to the off code must not act as a command
    task automatic t_dc_kind();
        dat(`OGR_CMD_DISP_OFF);
        check_bit(panel_on, 1'b1);
        pix(6'd1, 7'd2, 1'b1);
    endtask

    task automatic t_off_keeps();
        cmd(`OGR_CMD_DISP_OFF);
        check_bit(panel_on, 1'b0);
        pix(6'd0, 7'd0, 1'b0);
        cmd(`OGR_CMD_DISP_ON);
        wait_on();
        pix(6'd0, 7'd0, 1'b1);
    endtask

    // pin reset with serial straps, then a serial session
    task automatic t_serial();
        bus_sel    = `OGR_BS_SERIAL;
        hw_reset_n = 1'b0;
        repeat (80) @(posedge clock);
        #1;
        check_bit(panel_on, 1'b0);
        check_byte(dev_oe_n, 8'hFF);
        hw_reset_n = 1'b1;
        repeat (6) @(posedge clock);
        ogr_host_model_inst.ser_xfer(1'b0, `OGR_CMD_DISP_ON);
        wait_on();
        ogr_host_model_inst.ser_xfer(1'b0, 8'hB0);
        ogr_host_model_inst.ser_xfer(1'b0, 8'h00);
        ogr_host_model_inst.ser_xfer(1'b0, 8'h10);
        ogr_host_model_inst.ser_xfer(1'b1, 8'h55);
        pix(6'd0, 7'd0, 1'b1);
        pix(6'd1, 7'd0, 1'b0);
        pix(6'd2, 7'd0, 1'b1);
    endtask

    // pin reset with i2c straps, display-on sent over i2c
    task automatic t_i2c();
        logic [2:0] acks;
        bus_sel    = `OGR_BS_I2C;
        hw_reset_n = 1'b0;
        repeat (80) @(posedge clock);
        #1;
        hw_reset_n = 1'b1;
        repeat (6) @(posedge clock);
        ogr_host_model_inst.i2c_xfer({`OGR_I2C_ADDR, 1'b0}, 8'h00, `OGR_CMD_DISP_ON, acks);
        check_byte({5'h00, acks}, 8'h07);
        check_bit(panel_on, 1'b1);
        pix(6'd0, 7'd0, 1'b1);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (19) @(posedge clock);
        #1;
        check_byte(dev_oe_n, 8'hFF);
        check_bit(panel_on, 1'b0);
        @(posedge clock);
        #1;
        rst_b = 1'b1;
        repeat (6) @(posedge clock);
        t_layout();
        t_remap();
        t_start_line();
        t_cs_read();
        t_dc_kind();
        t_off_keeps();
        t_serial();
        t_i2c();
        print_verdict();
    end
endmodule

`default_nettype wire
